// ===== bssp_top.sv
// device-side read, write and echo clock logic of a four-word burst sync sram
`timescale 1ns/1ps

// Overview of operation
// (RULE1) low mask bit on a write beat stores that byte; other bytes stay
// (RULE2) mask bit n governs data bits 9n+8 down to 9n
// (RULE3) masks travel with the same beat as their data; high mask drops byte
// (RULE4) one address bus for reads and writes, taken on true strobe edges
// (RULE5) four arrays, each address picks four words; 19 address bits
// (RULE6) address bus ignored on edges where its port is not selected
// (RULE7) read data launched on output clock edges, or input strobes in single mode
// (RULE8) read data outputs released automatically when read port is deselected
// (RULE9) low read select on true strobe edge starts read at that address
// (RULE10) deselect lets read finish, then release after next output clock rise
// (RULE11) every read returns four consecutive words of the location
// (RULE12) true strobe edge captures inputs and starts every access
// (RULE13) complementary strobe edge also captures inputs and launches data
// (RULE14) free-running echo clock follows output clock, or input strobe in single mode
// (RULE15) controller supplies and may skew the output clock pair
// (RULE16) low write select on true strobe edge starts write; else data ignored
// (RULE17) controller puts read and write addresses on alternating true strobe edges
module bssp_top (
    clk_sys, // system clock
    nrst, // asynchronous reset, active low
    link_clk, // beat clock: one rising edge per strobe edge
    k_phase, // 1: this edge is a true input strobe rise
    c_phase, // 1: this edge is a true output clock rise
    single_clk_mode, // static strap: time reads from the input strobes
    addr_in, // shared address bus
    read_sel_n, // read port select, active low
    write_sel_n, // write port select, active low
    byte_lane_mask_n, // per-byte write masks, active low
    wr_data, // write data beat
    rd_data, // read data beat
    rd_data_oe_n, // read data output enable, low while driving
    returned_timing_pos, // echo clock, true
    returned_timing_neg, // echo clock, complementary
    rd_burst_count, // read bursts started, system domain
    wr_burst_count // write bursts started, system domain
);
    input logic clk_sys;
    input logic nrst;
    input logic link_clk;
    input logic k_phase;
    input logic c_phase;
    input logic single_clk_mode;
    input logic [bssp_pkg::ADDR_W-1:0] addr_in;
    input logic read_sel_n;
    input logic write_sel_n;
    input logic [bssp_pkg::LANES-1:0] byte_lane_mask_n;
    input logic [bssp_pkg::DATA_W-1:0] wr_data;
    output logic [bssp_pkg::DATA_W-1:0] rd_data;
    output logic rd_data_oe_n;
    output logic returned_timing_pos;
    output logic returned_timing_neg;
    output logic [bssp_pkg::CNT_W-1:0] rd_burst_count;
    output logic [bssp_pkg::CNT_W-1:0] wr_burst_count;

    bssp_pkg::bssp_link_t ln_reg;
    bssp_pkg::bssp_link_t ln_next;
    bssp_pkg::bssp_sys_t sy_reg;
    bssp_pkg::bssp_sys_t sy_next;

    logic [1:0] lrst_reg;
    logic link_rst_n;
    logic align;
    logic rd_hit;
    logic wr_hit;
    logic mem_re;
    logic [bssp_pkg::MEM_AW-1:0] mem_raddr;
    logic mem_we;
    logic [bssp_pkg::MEM_AW-1:0] mem_waddr;
    logic rd_event;
    logic wr_event;

    // reset for the link side: asserts at once, releases on link edges
    always_ff @(posedge link_clk or negedge nrst) begin
        if (!nrst) begin
            lrst_reg <= 2'h0;
        end else begin
            lrst_reg <= {lrst_reg[0], 1'b1};
        end
    end

    assign link_rst_n = lrst_reg[1];

    // link edges that are read launch points in the current clocking mode
    assign align = ln_reg.mode_sync ? k_phase : c_phase; // see (RULE7) (RULE13)
    // selects and address only count on true input strobe edges
    assign rd_hit = k_phase & ~read_sel_n; // see (RULE9) (RULE12)
    assign wr_hit = k_phase & ~write_sel_n; // see (RULE16) (RULE12)

    always_comb begin
        ln_next = ln_reg;
        mem_re = 1'b0;
        mem_raddr = {ln_reg.rd_addr, ln_reg.rd_beat};
        mem_we = 1'b0;
        mem_waddr = {ln_reg.wr_addr, ln_reg.wr_beat};

        // the strap is a pin level with no relation to the link clock
        ln_next.mode_meta = single_clk_mode;
        ln_next.mode_sync = ln_reg.mode_meta;

        // echo clock runs on every edge, selected or not
        ln_next.echo_pos = align; // see (RULE14)
        ln_next.echo_neg = ~align; // see (RULE14)

        case (ln_reg.rd_state)
            bssp_pkg::BSSP_RD_IDLE: begin
                if (rd_hit) begin
                    ln_next.rd_state = bssp_pkg::BSSP_RD_WAIT; // see (RULE9)
                    ln_next.rd_addr = addr_in; // see (RULE4) (RULE6)
                    ln_next.rd_beat = bssp_pkg::BEAT_FIRST;
                    ln_next.rd_tog = ~ln_reg.rd_tog;
                end
            end
            bssp_pkg::BSSP_RD_WAIT: begin
                // present the first word so it launches on the next aligned edge
                if (!align) begin
                    mem_re = 1'b1;
                    mem_raddr = {ln_reg.rd_addr, bssp_pkg::BEAT_FIRST};
                    ln_next.rd_beat = bssp_pkg::BEAT_SECOND; // see (RULE11)
                    ln_next.rd_state = bssp_pkg::BSSP_RD_RUN;
                    ln_next.rd_oe_n = 1'b0; // see (RULE7)
                end
                if (rd_hit) begin
                    ln_next.rd_pend = 1'b1;
                    ln_next.rd_pend_addr = addr_in; // see (RULE6)
                    ln_next.rd_tog = ~ln_reg.rd_tog;
                end
            end
            bssp_pkg::BSSP_RD_RUN: begin
                // one word per edge, consecutive beats of the same location
                mem_re = 1'b1; // see (RULE11) (RULE5)
                ln_next.rd_beat = ln_reg.rd_beat + bssp_pkg::BEAT_SECOND;
                if (ln_reg.rd_beat == bssp_pkg::BEAT_LAST) begin
                    ln_next.rd_beat = bssp_pkg::BEAT_FIRST;
                    if (ln_reg.rd_pend) begin
                        ln_next.rd_state = bssp_pkg::BSSP_RD_WAIT;
                        ln_next.rd_addr = ln_reg.rd_pend_addr;
                        ln_next.rd_pend = 1'b0;
                    end else if (rd_hit) begin
                        ln_next.rd_state = bssp_pkg::BSSP_RD_WAIT;
                        ln_next.rd_addr = addr_in;
                    end else begin
                        // deselected: the burst has finished, keep driving a while
                        ln_next.rd_state = bssp_pkg::BSSP_RD_DRAIN; // see (RULE10)
                    end
                end
                if (rd_hit) begin
                    ln_next.rd_tog = ~ln_reg.rd_tog;
                    if (ln_reg.rd_beat != bssp_pkg::BEAT_LAST || ln_reg.rd_pend) begin
                        ln_next.rd_pend = 1'b1;
                        ln_next.rd_pend_addr = addr_in;
                    end
                end
            end
            bssp_pkg::BSSP_RD_DRAIN: begin
                // last word holds until the next output clock rise, or input strobe rise in single mode, passes
                if (align) begin
                    ln_next.rd_oe_n = 1'b1; // see (RULE8) (RULE10)
                    ln_next.rd_state = bssp_pkg::BSSP_RD_IDLE;
                end
                if (rd_hit) begin
                    ln_next.rd_state = bssp_pkg::BSSP_RD_WAIT;
                    ln_next.rd_addr = addr_in;
                    ln_next.rd_beat = bssp_pkg::BEAT_FIRST;
                    ln_next.rd_tog = ~ln_reg.rd_tog;
                end
            end
            default: begin
                ln_next.rd_state = bssp_pkg::BSSP_RD_IDLE;
                ln_next.rd_oe_n = 1'b1;
            end
        endcase

        // writes: first beat rides with the select, three more follow on
        // the next strobe edges; a new select restarts the burst
        if (wr_hit) begin
            mem_we = 1'b1;
            mem_waddr = {addr_in, bssp_pkg::BEAT_FIRST}; // see (RULE4) (RULE6)
            ln_next.wr_addr = addr_in;
            ln_next.wr_beat = bssp_pkg::BEAT_SECOND;
            ln_next.wr_busy = 1'b1; // see (RULE16)
            ln_next.wr_tog = ~ln_reg.wr_tog;
        end else if (ln_reg.wr_busy) begin
            mem_we = 1'b1; // see (RULE13)
            ln_next.wr_beat = ln_reg.wr_beat + bssp_pkg::BEAT_SECOND;
            if (ln_reg.wr_beat == bssp_pkg::BEAT_LAST) begin
                ln_next.wr_busy = 1'b0;
                ln_next.wr_beat = bssp_pkg::BEAT_FIRST;
            end
        end
    end

    always_ff @(posedge link_clk or negedge link_rst_n) begin
        if (!link_rst_n) begin
            ln_reg.mode_meta <= 1'b0;
            ln_reg.mode_sync <= 1'b0;
            ln_reg.rd_state <= bssp_pkg::BSSP_RD_IDLE;
            ln_reg.rd_addr <= bssp_pkg::ADDR_RST;
            ln_reg.rd_beat <= bssp_pkg::BEAT_FIRST;
            ln_reg.rd_pend <= 1'b0;
            ln_reg.rd_pend_addr <= bssp_pkg::ADDR_RST;
            ln_reg.rd_oe_n <= 1'b1;
            ln_reg.wr_busy <= 1'b0;
            ln_reg.wr_beat <= bssp_pkg::BEAT_FIRST;
            ln_reg.wr_addr <= bssp_pkg::ADDR_RST;
            ln_reg.echo_pos <= 1'b0;
            ln_reg.echo_neg <= 1'b1;
            ln_reg.rd_tog <= 1'b0;
            ln_reg.wr_tog <= 1'b0;
        end else begin
            ln_reg <= ln_next;
        end
    end

    // four byte lanes; each mask bit gates only its own nine data bits
    genvar gi;
    generate
        for (gi = 0; gi < bssp_pkg::LANES; gi++) begin : g_lane
            bssp_lane #(
                .W(bssp_pkg::LANE_W),
                .AW(bssp_pkg::MEM_AW)
            ) u_lane (
                .clk(link_clk),
                .rst_n(link_rst_n),
                .we(mem_we & ~byte_lane_mask_n[gi]), // see (RULE1) (RULE3)
                .waddr(mem_waddr),
                .wdata(wr_data[gi*bssp_pkg::LANE_W +: bssp_pkg::LANE_W]), // see (RULE2)
                .re(mem_re),
                .raddr(mem_raddr),
                .rdata(rd_data[gi*bssp_pkg::LANE_W +: bssp_pkg::LANE_W])
            );
        end
    endgenerate

    assign rd_data_oe_n = ln_reg.rd_oe_n; // see (RULE8)
    assign returned_timing_pos = ln_reg.echo_pos;
    assign returned_timing_neg = ln_reg.echo_neg;

    // burst starts cross as toggles; a toggle survives any clock ratio as
    // long as starts are at least three system cycles apart
    assign rd_event = sy_reg.rd_sync[2] ^ sy_reg.rd_sync[1];
    assign wr_event = sy_reg.wr_sync[2] ^ sy_reg.wr_sync[1];

    always_comb begin
        sy_next = sy_reg;
        sy_next.rd_sync = {sy_reg.rd_sync[1:0], ln_reg.rd_tog};
        sy_next.wr_sync = {sy_reg.wr_sync[1:0], ln_reg.wr_tog};
        if (rd_event) begin
            sy_next.rd_count = sy_reg.rd_count + 16'h0001;
        end
        if (wr_event) begin
            sy_next.wr_count = sy_reg.wr_count + 16'h0001;
        end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            sy_reg.rd_sync <= 3'h0;
            sy_reg.wr_sync <= 3'h0;
            sy_reg.rd_count <= bssp_pkg::CNT_RST;
            sy_reg.wr_count <= bssp_pkg::CNT_RST;
        end else begin
            sy_reg <= sy_next;
        end
    end

    assign rd_burst_count = sy_reg.rd_count;
    assign wr_burst_count = sy_reg.wr_count;
endmodule

// ===== bssp_pkg.sv
// constants and state types shared by the burst sram port design
package bssp_pkg;
    localparam int DATA_W = 36;
    localparam int LANES = 4;
    localparam int LANE_W = 9;
    localparam int ADDR_W = 19;
    localparam int BEAT_W = 2;
    localparam int MEM_AW = ADDR_W + BEAT_W;
    localparam int CNT_W = 16;
    localparam logic [BEAT_W-1:0] BEAT_FIRST = 2'h0;
    localparam logic [BEAT_W-1:0] BEAT_SECOND = 2'h1;
    localparam logic [BEAT_W-1:0] BEAT_LAST = 2'h3;
    localparam logic [CNT_W-1:0] CNT_RST = 16'h0000;
    localparam logic [ADDR_W-1:0] ADDR_RST = 19'h00000;
    localparam logic [LANE_W-1:0] LANE_RST = 9'h000;

    typedef enum logic [1:0] {
        BSSP_RD_IDLE,
        BSSP_RD_WAIT,
        BSSP_RD_RUN,
        BSSP_RD_DRAIN
    } bssp_rd_state_t;

    typedef struct packed {
        logic mode_meta;
        logic mode_sync;
        bssp_rd_state_t rd_state;
        logic [ADDR_W-1:0] rd_addr;
        logic [BEAT_W-1:0] rd_beat;
        logic rd_pend;
        logic [ADDR_W-1:0] rd_pend_addr;
        logic rd_oe_n;
        logic wr_busy;
        logic [BEAT_W-1:0] wr_beat;
        logic [ADDR_W-1:0] wr_addr;
        logic echo_pos;
        logic echo_neg;
        logic rd_tog;
        logic wr_tog;
    } bssp_link_t;

    typedef struct packed {
        logic [2:0] rd_sync;
        logic [2:0] wr_sync;
        logic [CNT_W-1:0] rd_count;
        logic [CNT_W-1:0] wr_count;
    } bssp_sys_t;
endpackage

// ===== bssp_lane.sv
// one byte lane of the storage array with masked write and registered read
`timescale 1ns/1ps

module bssp_lane #(
    parameter int W = 9,
    parameter int AW = 21
) (
    clk, // link clock
    rst_n, // link-domain reset, active low
    we, // store wdata at waddr this edge
    waddr, // write word address
    wdata, // write byte
    re, // load rdata from raddr this edge
    raddr, // read word address
    rdata // registered read byte
);
    input logic clk;
    input logic rst_n;
    input logic we;
    input logic [AW-1:0] waddr;
    input logic [W-1:0] wdata;
    input logic re;
    input logic [AW-1:0] raddr;
    output logic [W-1:0] rdata;

    logic [W-1:0] mem [0:(1<<AW)-1];
    logic [W-1:0] rdata_reg;

    // the array itself has no reset, as in a real sram
    always_ff @(posedge clk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata_reg <= '0;
        end else if (re) begin
            rdata_reg <= mem[raddr];
        end
    end

    assign rdata = rdata_reg;
endmodule

// ===== bssp_top_sva.sv
// concurrent checks on the burst sram port pins
`timescale 1ns/1ps
module bssp_top_sva (
    clk_sys, // system clock
    nrst, // reset, active low
    link_clk, // beat clock
    k_phase, // true strobe phase
    c_phase, // true output clock phase
    single_clk_mode, // strap
    read_sel_n, // read select
    write_sel_n, // write select
    rd_data, // read beat
    rd_data_oe_n, // low while driving
    returned_timing_pos, // echo, true
    returned_timing_neg, // echo, complement
    rd_burst_count // reads counted
);
    input logic clk_sys, nrst, link_clk, k_phase, c_phase, single_clk_mode, read_sel_n, write_sel_n;
    input logic rd_data_oe_n, returned_timing_pos, returned_timing_neg;
    input logic [bssp_pkg::DATA_W-1:0] rd_data;
    input logic [bssp_pkg::CNT_W-1:0] rd_burst_count;
    logic [3:0] idle_reg;
    logic [7:0] mode_reg;
    logic [7:0] up_reg;
    wire take = k_phase && !read_sel_n;
    wire oe_n = rd_data_oe_n;
    wire align = single_clk_mode ? k_phase : c_phase;
    // the strap is resynchronised, so only trust timing once it has been steady a while
    wire one = &mode_reg && single_clk_mode && &up_reg;
    wire zero = ~|mode_reg && !single_clk_mode && &up_reg;
    always_ff @(posedge link_clk or negedge nrst) begin
        if (!nrst) begin
            idle_reg <= 4'hf;
            mode_reg <= 8'h00;
            up_reg <= 8'h00;
        end else begin
            idle_reg <= take ? 4'h0 : idle_reg + {3'h0, idle_reg != 4'hf};
            mode_reg <= {mode_reg[6:0], single_clk_mode};
            up_reg <= {up_reg[6:0], 1'b1};
        end
    end
    a_echo_pair: assert property (@(posedge link_clk) disable iff (!nrst)
        returned_timing_neg != returned_timing_pos) else $error("echo halves equal");
    a_echo_follow: assert property (@(posedge link_clk) disable iff (!nrst)
        (one || zero) |-> returned_timing_pos == $past(align)) else $error("echo off its clock");
    a_read_lat_one: assert property (@(posedge link_clk) disable iff (!nrst)
        take && oe_n && idle_reg > 4'h7 && one |-> ##1 oe_n ##[1:2] !oe_n) else $error("single mode latency");
    a_read_lat_two: assert property (@(posedge link_clk) disable iff (!nrst)
        take && oe_n && idle_reg > 4'h7 && zero |-> ##1 oe_n ##[1:3] !oe_n) else $error("dual mode latency");
    a_burst_four: assert property (@(posedge link_clk) disable iff (!nrst)
        $fell(oe_n) |-> (!oe_n) [*4]) else $error("burst shorter than four");
    a_oe_release: assert property (@(posedge link_clk) disable iff (!nrst)
        (!take) [*2] ##1 ($fell(oe_n) && !take) ##1 (!take) [*4] |-> ##[0:1] oe_n) else $error("no release");
    a_data_hold: assert property (@(posedge link_clk) disable iff (!nrst)
        oe_n && $past(oe_n) |-> $stable(rd_data)) else $error("data moved while idle");
    a_rd_count: assert property (@(posedge clk_sys) disable iff (!nrst)
        rd_burst_count == $past(rd_burst_count) || rd_burst_count == $past(rd_burst_count) + 16'h1)
        else $error("read count jumped");
    c_read_one: cover property (@(posedge link_clk) take && one);
    c_read_two: cover property (@(posedge link_clk) take && zero);
    c_write: cover property (@(posedge link_clk) k_phase && !write_sel_n);
    c_release: cover property (@(posedge link_clk) $rose(oe_n));
endmodule

bind bssp_top bssp_top_sva bssp_top_sva_inst (.clk_sys(clk_sys), .nrst(nrst), .link_clk(link_clk),
    .k_phase(k_phase), .c_phase(c_phase), .single_clk_mode(single_clk_mode), .read_sel_n(read_sel_n),
    .write_sel_n(write_sel_n), .rd_data(rd_data), .rd_data_oe_n(rd_data_oe_n),
    .returned_timing_pos(returned_timing_pos), .returned_timing_neg(returned_timing_neg),
    .rd_burst_count(rd_burst_count));

// ===== bssp_ctrl_model.sv
// controller-side model making the beat clock and strobe phase flags
`timescale 1ns/1ps
module bssp_ctrl_model (
    link_clk, // beat clock, one rise per strobe edge
    k_phase, // true input strobe phase
    c_phase // true output clock phase
);
    output logic link_clk;
    output logic k_phase;
    output logic c_phase;
    initial begin
        link_clk = 1'b0;
        k_phase = 1'b0;
        c_phase = 1'b1;
        #7.3;
        forever #16 link_clk = ~link_clk;
    end
    // output pair lags the input pair by half a strobe period, as board skew would
    always @(posedge link_clk) begin
        k_phase <= ~k_phase;
        c_phase <= k_phase;
    end
endmodule

// ===== bssp_top_tb.sv
// self-checking bench for the burst sram port
`timescale 1ns/1ps
module bssp_top_tb;
    logic clk_sys = 1'b0, nrst = 1'b0, single_clk_mode = 1'b1, read_sel_n = 1'b1, write_sel_n = 1'b1;
    logic link_clk, k_phase, c_phase, rd_data_oe_n, returned_timing_pos, returned_timing_neg;
    logic prev_oe = 1'b1;
    logic [bssp_pkg::ADDR_W-1:0] addr_in = 19'h00000, a0;
    logic [bssp_pkg::LANES-1:0] byte_lane_mask_n = 4'hf;
    logic [bssp_pkg::DATA_W-1:0] wr_data = 36'h0, rd_data;
    logic [bssp_pkg::CNT_W-1:0] rd_burst_count, wr_burst_count;
    logic [bssp_pkg::DATA_W-1:0] mem [logic [bssp_pkg::MEM_AW-1:0]];
    logic [bssp_pkg::DATA_W-1:0] exp_q [$];
    int bad_count = 0, checks_done = 0, left = 0, n_rd = 0, n_wr = 0, mode, i;
    bssp_ctrl_model bssp_ctrl_model_inst (.link_clk(link_clk), .k_phase(k_phase), .c_phase(c_phase));
    bssp_top bssp_top_inst (.clk_sys(clk_sys), .nrst(nrst), .link_clk(link_clk), .k_phase(k_phase),
        .c_phase(c_phase), .single_clk_mode(single_clk_mode), .addr_in(addr_in), .read_sel_n(read_sel_n),
        .write_sel_n(write_sel_n), .byte_lane_mask_n(byte_lane_mask_n), .wr_data(wr_data),
        .rd_data(rd_data), .rd_data_oe_n(rd_data_oe_n), .returned_timing_pos(returned_timing_pos),
        .returned_timing_neg(returned_timing_neg), .rd_burst_count(rd_burst_count),
        .wr_burst_count(wr_burst_count));
    initial begin
        forever #12.5 clk_sys = ~clk_sys;
    end
    task automatic check(input logic [35:0] exp, input logic [35:0] got);
        checks_done++;
        if (got !== exp) begin
            bad_count++;
            $display("unexpected at %0t: expected %h got %h", $time, exp, got);
        end
    endtask
    task automatic test_done;
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    // returns on the edge before a true strobe rise, so the next drive lands on it
    task automatic to_true_rise;
        int n;
        n = 0;
        @(negedge link_clk);
        while (k_phase !== 1'b0 && n < 8) begin
            @(negedge link_clk);
            n++;
        end
        if (k_phase !== 1'b0) begin
            bad_count++;
            test_done();
        end
        @(posedge link_clk);
    endtask
    task automatic wr_burst(input logic [18:0] a, input bit rnd);
        int b, n;
        logic [63:0] d;
        logic [3:0] m;
        logic [35:0] w;
        to_true_rise();
        for (b = 0; b < 4; b++) begin
            d = {$urandom, $urandom};
            m = rnd ? 4'($urandom) : 4'h0;
            w = rnd ? mem[{a, 2'(b)}] : 36'h0;
            write_sel_n <= (b != 0);
            addr_in <= (b == 0) ? a : a ^ 19'h00001;
            wr_data <= d[35:0];
            byte_lane_mask_n <= m;
            for (n = 0; n < 4; n++) begin
                if (!m[n]) begin
                    w[9*n +: 9] = d[9*n +: 9];
                end
            end
            mem[{a, 2'(b)}] = w;
            @(posedge link_clk);
        end
        byte_lane_mask_n <= 4'hf;
        n_wr++;
    endtask
    task automatic rd_burst(input logic [18:0] a);
        int b;
        to_true_rise();
        read_sel_n <= 1'b0;
        addr_in <= a;
        for (b = 0; b < 4; b++) begin
            exp_q.push_back(mem[{a, 2'(b)}]);
        end
        @(posedge link_clk);
        read_sel_n <= 1'b1;
        addr_in <= a ^ 19'h00001;
        n_rd++;
        repeat (12) @(posedge link_clk);
    endtask
    // outputs read here are those launched by the previous beat edge
    always @(posedge link_clk) begin
        if (left > 0 || (prev_oe === 1'b1 && rd_data_oe_n === 1'b0)) begin
            if (exp_q.size() == 0) begin
                check(36'h0, rd_data);
            end else begin
                check(exp_q.pop_front(), rd_data);
            end
            left = (left > 0) ? left - 1 : 3;
        end
        prev_oe = rd_data_oe_n;
    end
    initial begin
        #100000;
        bad_count++;
        test_done();
    end
    initial begin
        void'($urandom(32'hf4ea));
        repeat (10) @(posedge clk_sys);
        nrst <= 1'b1;
        repeat (8) @(posedge link_clk);
        for (mode = 1; mode >= 0; mode--) begin
            single_clk_mode <= mode[0];
            repeat (6) @(posedge link_clk);
            a0 = mode ? 19'h7ffff : 19'($urandom);
            wr_burst(a0, 1'b0);
            wr_burst(a0 ^ 19'h00001, 1'b0);
            wr_burst(a0, 1'b1);
            rd_burst(a0);
            rd_burst(a0 ^ 19'h00001);
            $display("mode %0d test done", mode);
        end
        for (i = 0; i < 40 && exp_q.size() > 0; i++) begin
            @(posedge link_clk);
        end
        if (exp_q.size() > 0) begin
            bad_count++;
        end
        repeat (8) @(posedge clk_sys);
        check(36'(n_rd), {20'h0, rd_burst_count});
        check(36'(n_wr), {20'h0, wr_burst_count});
        test_done();
    end
endmodule
